// [hw/dmae_pkg.sv]
// Package: constants, register map and types for the DMA mode engine
package dmae_pkg;
  localparam int NUM_CH = 3;
  localparam int AW = 16;
  localparam int DW = 16;
  localparam int NUM_TRIG = 8;
  localparam int ADDR_BITS = 4;
  localparam int STEPS_PER_MOVE = 2;
  localparam int BURST_MOVES = 4;
  localparam int BURST_GAP = 2;
  // Register indices per channel, channel base = ch * CH_STRIDE
  localparam logic [3:0] CH_STRIDE = 4'h4;
  localparam logic [1:0] OFF_CTL = 2'h0;
  localparam logic [1:0] OFF_SRC = 2'h1;
  localparam logic [1:0] OFF_DST = 2'h2;
  localparam logic [1:0] OFF_SIZE = 2'h3;
  localparam logic [3:0] OFF_PRIO = 4'hC;
  // Control word fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_SRCSTEP_LSB = 3;
  localparam int CTL_DSTSTEP_LSB = 5;
  localparam int CTL_SOURCE_WIDTH_SELECT = 7;
  localparam int CTL_DEST_WIDTH_SELECT = 8;
  localparam int CTL_LEVEL = 9;
  localparam int CTL_TSEL_LSB = 10;
  localparam int CTL_EN = 13;
  localparam int CTL_DONE = 14;
  localparam logic [DW-1:0] CTL_RESET = 16'h0000;
  localparam logic [5:0] PRIO_RESET = 6'h24;
  localparam logic [1:0] STEP_HOLD = 2'h0;
  localparam logic [1:0] STEP_DEC = 2'h2;
  localparam logic [1:0] STEP_INC = 2'h3;
  localparam logic [2:0] MODE_SINGLE = 3'h0;
  localparam logic [2:0] MODE_BLOCK = 3'h1;
  localparam logic [2:0] MODE_RSINGLE = 3'h4;
  localparam logic [2:0] MODE_RBLOCK = 3'h5;
  typedef enum logic [1:0] {CH_IDLE, CH_ARMED, CH_BLOCK} dmae_ch_e;
  typedef enum logic [2:0] {EN_IDLE, EN_READ, EN_WRITE, EN_GAP} dmae_eng_e;
endpackage : dmae_pkg

// [hw/dmae_trig_sync.sv]
// Trigger synchroniser and per-channel trigger qualifier
`timescale 1ns/1ps
module dmae_trig_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [dmae_pkg::NUM_TRIG-1:0] trigIn,
  input wire logic [2:0] trigSel,
  input wire logic levelSel,
  output logic trigEvent,
  output logic trigLevel
);
  logic [dmae_pkg::NUM_TRIG-1:0] meta_reg;
  logic [dmae_pkg::NUM_TRIG-1:0] sync_reg;
  logic last_reg;
  logic selBit;
  assign selBit = sync_reg[trigSel];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= trigIn;
      sync_reg <= meta_reg;
      last_reg <= selBit;
    end
  end
  // Last starts high, but sync starts low, so a trigger already high at reset still gives an edge after two clocks
  assign trigEvent = !levelSel && selBit && !last_reg;
  assign trigLevel = levelSel && selBit;
endmodule : dmae_trig_sync

// [hw/dmae_engine.sv]
// DMA mode engine: channel registers, triggers, arbitration and bus moves
//
// Contract
// - Three channels, each with private address, width and mode settings.
// - Every move holds the bus exactly two clocks, processor stalled.
// - Size counter is sixteen bits, up to 65535 units.
// - Channel priority order is held in a writable register.
// - Each channel selects which trigger input starts it.
// - Each channel picks edge or level triggering.
// - Source and destination stepping chosen per channel, all four combos.
// - After each move addresses step up, down or hold independently.
// - Source and destination each byte or word wide.
// - Word to byte writes only the low eight bits.
// - Byte to word zeroes the upper destination byte.
// - Three-bit mode field picks six modes, independent of addressing.
// - Mode 000: one move per trigger, enable cleared at count end.
// - Mode 001: whole block per trigger, enable cleared at end.
// - Burst codes clear enable at end; repeated burst codes keep it.
// - Mode 100: one move per trigger, enable stays set.
// - Mode 101: whole block per trigger, enable stays set.
// - A size of zero gives no moves even when triggered.
// - Working count decrements; at zero reloads and sets done flag.
// - Burst modes release the bus two clocks every four moves.
// - Edge mode starts on rising edge of the selected trigger.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module dmae_engine (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [dmae_pkg::ADDR_BITS-1:0] regAddr,
  input wire logic [dmae_pkg::DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [dmae_pkg::DW-1:0] regRdata,
  input wire logic [dmae_pkg::NUM_TRIG-1:0] trigIn,
  output logic busReq,
  output logic cpuHold,
  output logic [dmae_pkg::AW-1:0] memAddr,
  output logic memRd,
  output logic memWr,
  output logic memByte,
  output logic [dmae_pkg::DW-1:0] memWdata,
  input wire logic [dmae_pkg::DW-1:0] memRdata
);
  localparam int N = dmae_pkg::NUM_CH;
  logic [dmae_pkg::DW-1:0] ctl_reg [N];
  logic [dmae_pkg::AW-1:0] srcCfg_reg [N];
  logic [dmae_pkg::AW-1:0] dstCfg_reg [N];
  logic [dmae_pkg::DW-1:0] sizeCfg_reg [N];
  logic [dmae_pkg::AW-1:0] srcWork_reg [N];
  logic [dmae_pkg::AW-1:0] dstWork_reg [N];
  logic [dmae_pkg::DW-1:0] cnt_reg [N];
  dmae_pkg::dmae_ch_e chState_reg [N];
  logic [5:0] prio_reg;
  logic [dmae_pkg::DW-1:0] regRdata_reg;
  dmae_pkg::dmae_eng_e eng_reg;
  logic [1:0] act_reg;
  logic [1:0] burstCnt_reg;
  logic gapCnt_reg;
  logic busReq_reg;
  logic cpuHold_reg;
  logic [dmae_pkg::AW-1:0] memAddr_reg;
  logic memRd_reg;
  logic memWr_reg;
  logic memByte_reg;
  logic [dmae_pkg::DW-1:0] memWdata_reg;
  logic [N-1:0] trigEvent;
  logic [N-1:0] trigLevel;
  logic [N-1:0] ready;
  logic [N-1:0] isBlock;
  logic [N-1:0] isBurst;
  logic [N-1:0] isRepeat;
  logic [N-1:0] chEn;
  logic [N-1:0] wrCh;
  logic wrPrio;
  logic [1:0] regCh;
  logic [1:0] regOff;
  logic [1:0] pick;
  logic pickValid;
  logic lastMove;
  logic [2:0] actMode;
  logic [dmae_pkg::DW-1:0] moveData;
  logic [dmae_pkg::DW-1:0] rdMux;
  logic [dmae_pkg::AW-1:0] srcStepped;
  logic [dmae_pkg::AW-1:0] dstStepped;

  assign regCh = regAddr[3:2];
  assign regOff = regAddr[1:0];
  assign wrPrio = regWr && (regAddr == dmae_pkg::OFF_PRIO);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gCh
      logic [2:0] md;
      assign md = ctl_reg[g][dmae_pkg::CTL_MODE_LSB +: 3];
      assign chEn[g] = ctl_reg[g][dmae_pkg::CTL_EN];
      assign wrCh[g] = regWr && (regCh == 2'(g));
      assign isBurst[g] = md[1];
      assign isBlock[g] = (md[1:0] != 2'h0);
      assign isRepeat[g] = md[2];
      dmae_trig_sync uSync (
        .clk(clk),
        .rstn(rstn),
        .trigIn(trigIn),
        .trigSel(ctl_reg[g][dmae_pkg::CTL_TSEL_LSB +: 3]),
        .levelSel(ctl_reg[g][dmae_pkg::CTL_LEVEL]),
        .trigEvent(trigEvent[g]),
        .trigLevel(trigLevel[g])
      );
      // Level mode pauses a block when the trigger drops
      assign ready[g] = chEn[g] && (sizeCfg_reg[g] != '0) &&
        ((chState_reg[g] == dmae_pkg::CH_ARMED) || trigLevel[g] ||
         (chState_reg[g] == dmae_pkg::CH_BLOCK &&
          !ctl_reg[g][dmae_pkg::CTL_LEVEL]));
    end
  endgenerate

  // Priority register holds three 2-bit channel numbers, highest first
  always_comb begin
    pick = 2'h0;
    pickValid = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if ((prio_reg[2*i +: 2] < 2'(N)) && ready[prio_reg[2*i +: 2]]) begin
        pick = prio_reg[2*i +: 2];
        pickValid = 1'b1;
      end
    end
  end

  assign actMode = ctl_reg[act_reg][dmae_pkg::CTL_MODE_LSB +: 3];
  assign lastMove = (cnt_reg[act_reg] == 16'h0001);
  assign moveData = ctl_reg[act_reg][dmae_pkg::CTL_SOURCE_WIDTH_SELECT] ||
    ctl_reg[act_reg][dmae_pkg::CTL_DEST_WIDTH_SELECT] ?
    {8'h00, memRdata[7:0]} : memRdata;

  function automatic logic [dmae_pkg::AW-1:0] stepAddr(
    input logic [dmae_pkg::AW-1:0] a,
    input logic [1:0] sel,
    input logic isByte
  );
    logic [dmae_pkg::AW-1:0] d;
    d = isByte ? 16'h0001 : 16'h0002;
    if (sel == dmae_pkg::STEP_INC) stepAddr = a + d;
    else if (sel == dmae_pkg::STEP_DEC) stepAddr = a - d;
    else stepAddr = a;
  endfunction : stepAddr

  assign srcStepped = stepAddr(srcWork_reg[act_reg],
    ctl_reg[act_reg][dmae_pkg::CTL_SRCSTEP_LSB +: 2],
    ctl_reg[act_reg][dmae_pkg::CTL_SOURCE_WIDTH_SELECT]);
  assign dstStepped = stepAddr(dstWork_reg[act_reg],
    ctl_reg[act_reg][dmae_pkg::CTL_DSTSTEP_LSB +: 2],
    ctl_reg[act_reg][dmae_pkg::CTL_DEST_WIDTH_SELECT]);

  assign rdMux = (regAddr == dmae_pkg::OFF_PRIO) ? {10'h000, prio_reg} :
    (regCh >= 2'(N)) ? 16'h0000 :
    (regOff == dmae_pkg::OFF_CTL) ? ctl_reg[regCh] :
    (regOff == dmae_pkg::OFF_SRC) ? srcCfg_reg[regCh] :
    (regOff == dmae_pkg::OFF_DST) ? dstCfg_reg[regCh] : cnt_reg[regCh];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) regRdata_reg <= '0;
    else if (regRd) regRdata_reg <= rdMux;
    else regRdata_reg <= '0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) prio_reg <= dmae_pkg::PRIO_RESET;
    else if (wrPrio) prio_reg <= regWdata[5:0];
  end

  // Engine sequencing: read cycle then write cycle per move
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eng_reg <= dmae_pkg::EN_IDLE;
      act_reg <= 2'h0;
      burstCnt_reg <= 2'h0;
      gapCnt_reg <= 1'b0;
    end else begin
      unique case (eng_reg)
        dmae_pkg::EN_IDLE: begin
          if (pickValid) begin
            act_reg <= pick;
            eng_reg <= dmae_pkg::EN_READ;
          end
        end
        dmae_pkg::EN_READ: begin
          eng_reg <= dmae_pkg::EN_WRITE;
        end
        dmae_pkg::EN_WRITE: begin
          burstCnt_reg <= burstCnt_reg + 2'h1;
          gapCnt_reg <= 1'b0;
          if (isBurst[act_reg] && !lastMove && burstCnt_reg == 2'h3) begin
            eng_reg <= dmae_pkg::EN_GAP;
          end else begin
            eng_reg <= dmae_pkg::EN_IDLE;
          end
          if (lastMove) burstCnt_reg <= 2'h0;
        end
        dmae_pkg::EN_GAP: begin
          gapCnt_reg <= 1'b1;
          if (gapCnt_reg) eng_reg <= dmae_pkg::EN_IDLE;
        end
        default: eng_reg <= dmae_pkg::EN_IDLE;
      endcase
    end
  end

  // Read data is registered at the end of the read cycle for the write cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busReq_reg <= 1'b0;
      cpuHold_reg <= 1'b0;
      memAddr_reg <= '0;
      memRd_reg <= 1'b0;
      memWr_reg <= 1'b0;
      memByte_reg <= 1'b0;
      memWdata_reg <= '0;
    end else begin
      memRd_reg <= (eng_reg == dmae_pkg::EN_IDLE) && pickValid;
      memWr_reg <= (eng_reg == dmae_pkg::EN_READ);
      busReq_reg <= ((eng_reg == dmae_pkg::EN_IDLE) && pickValid) ||
        (eng_reg == dmae_pkg::EN_READ);
      cpuHold_reg <= ((eng_reg == dmae_pkg::EN_IDLE) && pickValid) ||
        (eng_reg == dmae_pkg::EN_READ);
      if (eng_reg == dmae_pkg::EN_IDLE) begin
        memAddr_reg <= srcWork_reg[pick];
        memByte_reg <= ctl_reg[pick][dmae_pkg::CTL_SOURCE_WIDTH_SELECT];
      end else if (eng_reg == dmae_pkg::EN_READ) begin
        memAddr_reg <= dstWork_reg[act_reg];
        memByte_reg <= ctl_reg[act_reg][dmae_pkg::CTL_DEST_WIDTH_SELECT];
      end
      if (eng_reg == dmae_pkg::EN_READ) begin
        memWdata_reg <= moveData;
      end
    end
  end

  // Per-channel state: configuration writes and hardware updates
  for (g = 0; g < N; g++) begin : gChState
    logic moveDone;
    assign moveDone = (eng_reg == dmae_pkg::EN_WRITE) && (act_reg == 2'(g));
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ctl_reg[g] <= dmae_pkg::CTL_RESET;
        srcCfg_reg[g] <= '0;
        dstCfg_reg[g] <= '0;
        sizeCfg_reg[g] <= '0;
        srcWork_reg[g] <= '0;
        dstWork_reg[g] <= '0;
        cnt_reg[g] <= '0;
        chState_reg[g] <= dmae_pkg::CH_IDLE;
      end else if (wrCh[g]) begin
        unique case (regOff)
          dmae_pkg::OFF_CTL: begin
            // A finishing move sets done even against a clear
            ctl_reg[g] <= {1'b0, (moveDone && lastMove) ||
              (!regWdata[15] && ctl_reg[g][dmae_pkg::CTL_DONE]), regWdata[13:0]};
            if (!regWdata[dmae_pkg::CTL_EN]) chState_reg[g] <= dmae_pkg::CH_IDLE;
          end
          dmae_pkg::OFF_SRC: begin
            srcCfg_reg[g] <= regWdata;
            srcWork_reg[g] <= regWdata;
          end
          dmae_pkg::OFF_DST: begin
            dstCfg_reg[g] <= regWdata;
            dstWork_reg[g] <= regWdata;
          end
          dmae_pkg::OFF_SIZE: begin
            sizeCfg_reg[g] <= regWdata;
            cnt_reg[g] <= regWdata;
          end
        endcase
      end else if (moveDone) begin
        srcWork_reg[g] <= srcStepped;
        dstWork_reg[g] <= dstStepped;
        cnt_reg[g] <= cnt_reg[g] - 16'h0001;
        chState_reg[g] <= isBlock[g] ? dmae_pkg::CH_BLOCK : dmae_pkg::CH_IDLE;
        if (lastMove) begin
          cnt_reg[g] <= sizeCfg_reg[g];
          srcWork_reg[g] <= srcCfg_reg[g];
          dstWork_reg[g] <= dstCfg_reg[g];
          ctl_reg[g][dmae_pkg::CTL_DONE] <= 1'b1;
          ctl_reg[g][dmae_pkg::CTL_EN] <= isRepeat[g];
          // Repeated burst restarts without a new trigger
          chState_reg[g] <= (isRepeat[g] && isBurst[g]) ? dmae_pkg::CH_BLOCK :
            dmae_pkg::CH_IDLE;
        end
      end else if (chEn[g] && trigEvent[g] && chState_reg[g] == dmae_pkg::CH_IDLE) begin
        // Triggers during a running block are ignored
        chState_reg[g] <= isBlock[g] ? dmae_pkg::CH_BLOCK : dmae_pkg::CH_ARMED;
      end
    end
  end

  assign regRdata = regRdata_reg;
  assign busReq = busReq_reg;
  assign cpuHold = cpuHold_reg;
  assign memAddr = memAddr_reg;
  assign memRd = memRd_reg;
  assign memWr = memWr_reg;
  assign memByte = memByte_reg;
  assign memWdata = memWdata_reg;
endmodule : dmae_engine

// [tb/dmae_checker_assertions.sv]
// Checker: move timing and data lane properties at the engine ports
`timescale 1ns/1ps
module dmae_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic regRd,
  input wire logic [dmae_pkg::DW-1:0] regRdata,
  input wire logic busReq,
  input wire logic cpuHold,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic memByte,
  input wire logic [dmae_pkg::DW-1:0] memWdata,
  input wire logic [dmae_pkg::DW-1:0] memRdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_wr; memRd |=> memWr; endproperty
  property p_wr_src; memWr |-> $past(memRd); endproperty
  property p_two; $rose(busReq) |=> busReq ##1 !busReq; endproperty
  property p_cpu; busReq |-> cpuHold && (memRd || memWr); endproperty
  property p_pace; memWr |=> !memRd; endproperty
  property p_lane; memWr |-> memWdata[7:0] == $past(memRdata[7:0]); endproperty
  property p_byte; memWr && memByte |-> memWdata[15:8] == 8'h00; endproperty
  property p_rdz; !$past(regRd) |-> regRdata == 16'h0000; endproperty
  a_rd_wr: assert property (p_rd_wr)
    else $error("read cycle not followed by write");
  a_wr_src: assert property (p_wr_src)
    else $error("write cycle without read before");
  a_two: assert property (p_two)
    else $error("bus request not two cycles");
  a_cpu: assert property (p_cpu)
    else $error("processor not held during move");
  a_pace: assert property (p_pace)
    else $error("moves back to back");
  a_lane: assert property (p_lane)
    else $error("low byte not copied");
  a_byte: assert property (p_byte)
    else $error("byte write upper bits set");
  a_rdz: assert property (p_rdz)
    else $error("read data outside read slot");
  c_byte: cover property (memWr && memByte);
  c_move: cover property ($rose(busReq));
  c_read: cover property (regRd ##1 regRdata != 16'h0000);
endmodule : dmae_checker

// [tb/dmae_mem_model.sv]
// Memory model on the engine's bus; no stable data outside reads
`timescale 1ns/1ps
module dmae_mem_model (
  input wire logic clk,
  input wire logic [15:0] memAddr,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic memByte,
  input wire logic [15:0] memWdata,
  output logic [15:0] memRdata
);
  logic [15:0] mem [0:255];
  logic [15:0] junk = 16'h5A3C;
  wire [7:0] idx = memAddr[8:1];
  wire [7:0] lane = memAddr[0] ? mem[idx][15:8] : mem[idx][7:0];
  always @(posedge clk) begin
    junk <= {junk[14:0], junk[15] ^ junk[13]};
    if (memWr && memByte) mem[idx][memAddr[0]*8 +: 8] <= memWdata[7:0];
    else if (memWr) mem[idx] <= memWdata;
  end
  // Byte reads carry garbage above the lane so masking is exercised
  assign memRdata = !memRd ? junk : memByte ? {~lane, lane} : mem[idx];
endmodule : dmae_mem_model

// [tb/tb_top.sv]
// Testbench: register access, all transfer modes, widths and stepping
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic clk, rstn, regWr, regRd, keepLast, rdPend;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, memAddr, memWdata, memRdata;
  logic [7:0] trigIn;
  logic busReq, cpuHold, memRd, memWr, memByte;
  logic [15:0] img [0:255];
  logic [15:0] rq[$];
  logic [31:0] wq[$];
  int rdT[$];
  int fail_count, num_checks, nWr, cyc, seed, m;
  logic [15:0] c, rqHead;
  dmae_engine u_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .trigIn(trigIn), .busReq(busReq),
    .cpuHold(cpuHold), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
    .memByte(memByte), .memWdata(memWdata), .memRdata(memRdata));
  dmae_mem_model u_mem (.clk(clk), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
    .memByte(memByte), .memWdata(memWdata), .memRdata(memRdata));
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd
  function automatic logic [15:0] step(input logic [15:0] x, input logic [1:0] s,
      input logic byt);
    logic [15:0] u;
    u = byt ? 16'h0001 : 16'h0002;
    return s == dmae_pkg::STEP_INC ? x + u : s == dmae_pkg::STEP_DEC ? x - u : x;
  endfunction : step
  function automatic logic [15:0] ctl(input logic [2:0] md, input logic [1:0] ss, ds,
      input logic sb, db, lv, input logic [2:0] ts);
    return {3'b101, ts, lv, db, sb, ds, ss, md};
  endfunction : ctl
  task automatic run(input int ch, input logic [15:0] cw, s, d, sz, input int n);
    logic [15:0] a, b, v;
    int k, t;
    a = s;
    b = d;
    for (k = 0; k < n; k++) begin
      v = img[a[8:1]];
      if (cw[7]) v = {8'h00, a[0] ? v[15:8] : v[7:0]};
      if (cw[8]) v[15:8] = 8'h00;
      wq.push_back({b, v});
      a = step(a, cw[4:3], cw[7]);
      b = step(b, cw[6:5], cw[8]);
    end
    wr(4'(4 * ch + 1), s);
    wr(4'(4 * ch + 2), d);
    wr(4'(4 * ch + 3), sz);
    wr(4'(4 * ch), cw);
    t = nWr + n;
    repeat (3) @(posedge clk);
    trigIn[cw[12:10]] <= 1'b1;
    repeat (4) @(posedge clk);
    // Edge mode drops the trigger; level mode holds it until done
    if (!cw[9]) trigIn <= 8'h00;
    for (k = 0; k < 2000 && nWr < t; k++) @(posedge clk);
    if (cw[9]) trigIn <= 8'h00;
    repeat (8) @(posedge clk);
    if (n > 0) begin
      rd(4'(4 * ch), {2'b01, cw[2], cw[12:0]});
      rd(4'(4 * ch + 3), sz);
    end
  endtask : run
  always @(posedge clk) begin
    cyc++;
    if (memRd) rdT.push_back(cyc);
    if (rdPend) begin
      rqHead = rq.pop_front();
      `CHK(regRdata, rqHead)
    end
    if (memWr) begin
      nWr++;
      `CHK({memAddr, memWdata}, wq[0])
      if (!(keepLast && wq.size() == 1)) void'(wq.pop_front());
    end
    rdPend <= regRd;
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #300000;
    fail_count++;
    test_done();
  end
  initial begin
    {rstn, regWr, regRd, keepLast, rdPend} = 5'h00;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    trigIn = 8'h00;
    seed = 32'h2069;
    for (m = 0; m < 256; m++) begin
      img[m] = 16'($random(seed));
      u_mem.mem[m] = img[m];
    end
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (m = 0; m < 3; m++) rd(4'(4 * m), dmae_pkg::CTL_RESET);
    rd(dmae_pkg::OFF_PRIO, {10'h000, dmae_pkg::PRIO_RESET});
    rd(4'hF, 16'h0000);
    wr(dmae_pkg::OFF_PRIO, 16'h0012);
    rd(dmae_pkg::OFF_PRIO, 16'h0012);
    // Every mode code, each on its own trigger input
    for (m = 0; m < 8; m++) begin
      keepLast = m[2] & m[1];
      c = ctl(3'(m), 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 3'(m));
      run(m % 3, c, 16'(16 + 2 * m), 16'(256 + 2 * m), 16'h0001, 1);
      if (keepLast) begin
        wr(4'(4 * (m % 3)), 16'h0000);
        repeat (10) @(posedge clk);
        wq.delete();
        keepLast = 1'b0;
      end
    end
    c = ctl(dmae_pkg::MODE_SINGLE, dmae_pkg::STEP_INC, dmae_pkg::STEP_DEC, 1'b0, 1'b0, 1'b1,
      3'h3);
    run(1, c, 16'h0020, 16'h0140, 16'h0003, 3);
    c = ctl(dmae_pkg::MODE_BLOCK, dmae_pkg::STEP_DEC, dmae_pkg::STEP_INC, 1'b1, 1'b0, 1'b0,
      3'h6);
    run(2, c, 16'h0031, 16'h0160, 16'h0003, 3);
    rdT.delete();
    c = ctl(3'h2, dmae_pkg::STEP_INC, dmae_pkg::STEP_INC, 1'b0, 1'b1, 1'b0, 3'h1);
    run(0, c, 16'h0040, 16'h0181, 16'h0006, 6);
    `CHK(rdT[4] - rdT[3], rdT[3] - rdT[2] + dmae_pkg::BURST_GAP)
    c = ctl(dmae_pkg::MODE_BLOCK, dmae_pkg::STEP_INC, dmae_pkg::STEP_INC, 1'b0, 1'b0, 1'b0,
      3'h2);
    m = nWr;
    run(0, c, 16'h0050, 16'h01A0, 16'h0000, 0);
    repeat (40) @(posedge clk);
    `CHK(wq.size(), 0)
    `CHK(nWr, m)
    test_done();
  end
endmodule : tb_top
bind dmae_engine dmae_checker u_chk (.clk(clk), .rstn(rstn), .regRd(regRd),
  .regRdata(regRdata), .busReq(busReq), .cpuHold(cpuHold), .memRd(memRd), .memWr(memWr),
  .memByte(memByte), .memWdata(memWdata), .memRdata(memRdata));
